// file: hdl/scg_params.svh
`ifndef SCG_PARAMS_SVH
`define SCG_PARAMS_SVH

// Sleep mode select encodings
`define SCG_MODE_IDLE 3'h0
`define SCG_MODE_NOISE 3'h1
`define SCG_MODE_PDOWN 3'h2
`define SCG_MODE_PSAVE 3'h3
`define SCG_MODE_STBY 3'h6
`define SCG_MODE_XSTBY 3'h7

// Bit positions in the clock enable vector
`define SCG_CK_CPU 6
`define SCG_CK_FLASH 5
`define SCG_CK_IO 4
`define SCG_CK_CONV 3
`define SCG_CK_ASY 2
`define SCG_CK_MAIN 1
`define SCG_CK_TOSC 0

// Clock enable vector while reset is held: timer oscillator off
`define SCG_CK_RESET 7'h7E

// Wake timing in clock cycles
`define SCG_WAKE_STBY_CYC 6
`define SCG_WAKE_HALT_CYC 4
`define SCG_STARTUP_CYC 64

`endif

// file: hdl/scg_pkg.sv
package scg_pkg;

    typedef enum logic [1:0] {
        SCG_RUN,
        SCG_SLEEP,
        SCG_WAKE
    } scg_state_e;

    typedef logic [6:0] scg_clk_t;

endpackage

// file: hdl/scg_sleep_ctrl.sv
`timescale 1ns/1ps
`include "scg_params.svh"

module scg_sleep_ctrl #(
    parameter int CNT_W = 16,
    parameter logic [15:0] STARTUP_CYC = 16'(`SCG_STARTUP_CYC)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sleep_instr,
    input wire logic sleep_enable_bit,
    input wire logic [2:0] sleep_mode_select,
    input wire logic xtal_clock_source,
    input wire logic async_timer_clock_select,
    input wire logic ext_irq_zero,
    input wire logic ext_irq_one,
    input wire logic ext_irq_two,
    input wire logic ext_irq_zero_level,
    input wire logic ext_irq_one_level,
    input wire logic two_wire_serial_match,
    input wire logic timer2_irq,
    input wire logic self_program_store_ready,
    input wire logic converter_done,
    input wire logic other_io_irq,
    input wire logic converter_enable,
    input wire logic conversion_start,
    input wire logic comparator_enable,
    input wire logic comparator_uses_ref,
    input wire logic brownout_enable_fuse,
    input wire logic watchdog_enable,
    input wire logic debug_enable_fuse,
    input wire logic scan_port_enable_fuse,
    input wire logic scan_port_disable_bit,
    input wire logic tap_shifting,
    input wire logic tap_data_out,
    output logic cpu_clock_domain,
    output logic flash_clock_domain,
    output logic io_clock_domain,
    output logic converter_clock_domain,
    output logic async_clock_domain,
    output logic main_osc_en,
    output logic timer_osc_en,
    output logic in_sleep,
    output logic converter_power,
    output logic comparator_power,
    output logic vref_power,
    output logic brownout_power,
    output logic watchdog_run,
    output logic input_buf_en,
    output logic [2:0] ext_irq_buf_en,
    output logic extended_conv,
    output logic scan_data_out,
    output logic scan_data_oe_n
);

    scg_pkg::scg_state_e st, next_st;
    logic [2:0] mode_q, next_mode_q;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic [2:0] sync1, sync2, sync3, irq_filt, next_irq_filt;
    logic conv_en_q;
    logic [2:0] req_mode;
    logic scan_en, debug_keep, wake_hit, deep;
    scg_pkg::scg_clk_t ck, next_ck;
    logic next_in_sleep, next_comp_pwr, next_vref, next_buf;
    logic [2:0] next_ext_buf;
    logic next_ext_conv, next_tdo, next_tdo_oe_n;

    default clocking cb_main @(posedge clk); endclocking
    default disable iff (rst);

    // Clock domains enabled for a given state and mode
    function automatic scg_pkg::scg_clk_t clk_plan(
        input scg_pkg::scg_state_e s,
        input logic [2:0] m,
        input logic as2,
        input logic keep
    );
        scg_pkg::scg_clk_t c;
        c = {6'h3F, as2};
        if (s != scg_pkg::SCG_RUN) begin
            c[`SCG_CK_CPU:`SCG_CK_FLASH] = 2'h0;
        end
        if (s == scg_pkg::SCG_SLEEP) begin
            case (m)
                `SCG_MODE_IDLE: c[`SCG_CK_IO] = 1'b1;
                `SCG_MODE_NOISE: c[`SCG_CK_IO] = 1'b0;
                `SCG_MODE_PDOWN:
                    c[`SCG_CK_IO:`SCG_CK_TOSC] = {3'h0, keep, 1'b0};
                `SCG_MODE_PSAVE:
                    c[`SCG_CK_IO:`SCG_CK_MAIN] = {2'h0, as2, keep};
                `SCG_MODE_STBY: c[`SCG_CK_IO:`SCG_CK_TOSC] = 5'h02;
                `SCG_MODE_XSTBY:
                    c[`SCG_CK_IO:`SCG_CK_MAIN] = {2'h0, as2, 1'b1};
                default: c[`SCG_CK_IO:`SCG_CK_TOSC] = 5'h00;
            endcase
        end
        return c;
    endfunction

    // External interrupt pins: three flops, change taken when two agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            sync3 <= 3'h0;
            irq_filt <= 3'h0;
        end else begin
            sync1 <= {ext_irq_two, ext_irq_one, ext_irq_zero};
            sync2 <= sync1;
            sync3 <= sync2;
            irq_filt <= next_irq_filt;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_filt
            assign next_irq_filt[gi] = (sync2[gi] == sync3[gi]) ?
                sync2[gi] : irq_filt[gi];
        end
    endgenerate

    always_comb begin
        scan_en = scan_port_enable_fuse & ~scan_port_disable_bit;
        debug_keep = debug_enable_fuse & scan_en;
        deep = (mode_q != `SCG_MODE_IDLE);
        // Standby modes without a crystal fall back to their non-oscillator forms
        req_mode = sleep_mode_select;
        if (sleep_mode_select[2:1] == 2'h3 && !xtal_clock_source) begin
            req_mode = {1'b0, 1'b1, sleep_mode_select[0]};
        end
        wake_hit = two_wire_serial_match;
        if (!deep) begin
            wake_hit = wake_hit | (|irq_filt) | other_io_irq;
        end else begin
            wake_hit = wake_hit | irq_filt[2] |
                (irq_filt[1] & ext_irq_one_level) |
                (irq_filt[0] & ext_irq_zero_level);
        end
        if (mode_q == `SCG_MODE_IDLE || mode_q == `SCG_MODE_NOISE) begin
            wake_hit = wake_hit | timer2_irq | converter_done |
                self_program_store_ready;
        end
        if ((mode_q == `SCG_MODE_PSAVE || mode_q == `SCG_MODE_XSTBY) &&
            async_timer_clock_select) begin
            wake_hit = wake_hit | timer2_irq;
        end
    end

    always_comb begin
        next_st = st;
        next_mode_q = mode_q;
        next_cnt = cnt;
        case (st)
            scg_pkg::SCG_RUN: begin
                if (sleep_instr && sleep_enable_bit &&
                    req_mode[2:1] != 2'h2) begin
                    next_st = scg_pkg::SCG_SLEEP;
                    next_mode_q = req_mode;
                end
            end
            scg_pkg::SCG_SLEEP: begin
                if (wake_hit) begin
                    next_st = scg_pkg::SCG_WAKE;
                    if (mode_q[2]) begin
                        next_cnt = CNT_W'(`SCG_WAKE_STBY_CYC - 1);
                    end else if (!mode_q[1]) begin
                        next_cnt = CNT_W'(`SCG_WAKE_HALT_CYC - 1);
                    end else begin
                        next_cnt = CNT_W'(STARTUP_CYC) +
                            CNT_W'(`SCG_WAKE_HALT_CYC - 1);
                    end
                end
            end
            scg_pkg::SCG_WAKE: begin
                if (cnt == '0) begin
                    next_st = scg_pkg::SCG_RUN;
                end else begin
                    next_cnt = cnt - CNT_W'(1);
                end
            end
            default: next_st = scg_pkg::SCG_RUN;
        endcase
    end

    always_comb begin
        next_ck = clk_plan(next_st, next_mode_q,
            async_timer_clock_select, debug_keep);
        next_in_sleep = (next_st == scg_pkg::SCG_SLEEP);
        next_comp_pwr = comparator_enable & (!next_in_sleep ||
            next_mode_q[2:1] == 2'h0);
        next_vref = brownout_enable_fuse | converter_enable |
            (comparator_enable & comparator_uses_ref) |
            next_comp_pwr;
        next_buf = next_ck[`SCG_CK_IO] | next_ck[`SCG_CK_CONV];
        next_ext_buf = {3{next_buf}} | {1'b1, ext_irq_one_level,
            ext_irq_zero_level};
        next_ext_conv = (converter_enable & ~conv_en_q) |
            (extended_conv & ~conversion_start);
        next_tdo_oe_n = ~(scan_en & tap_shifting);
        next_tdo = scan_en & tap_shifting & tap_data_out;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= scg_pkg::SCG_RUN;
            mode_q <= `SCG_MODE_IDLE;
            cnt <= '0;
            conv_en_q <= 1'b0;
            ck <= `SCG_CK_RESET;
            in_sleep <= 1'b0;
            converter_power <= 1'b0;
            comparator_power <= 1'b0;
            vref_power <= 1'b0;
            brownout_power <= 1'b0;
            watchdog_run <= 1'b0;
            input_buf_en <= 1'b1;
            ext_irq_buf_en <= 3'h7;
            extended_conv <= 1'b0;
            scan_data_out <= 1'b0;
            scan_data_oe_n <= 1'b1;
        end else begin
            st <= next_st;
            mode_q <= next_mode_q;
            cnt <= next_cnt;
            conv_en_q <= converter_enable;
            ck <= next_ck;
            in_sleep <= next_in_sleep;
            converter_power <= converter_enable;
            comparator_power <= next_comp_pwr;
            vref_power <= next_vref;
            brownout_power <= brownout_enable_fuse;
            watchdog_run <= watchdog_enable;
            input_buf_en <= next_buf;
            ext_irq_buf_en <= next_ext_buf;
            extended_conv <= next_ext_conv;
            scan_data_out <= next_tdo;
            scan_data_oe_n <= next_tdo_oe_n;
        end
    end

    assign cpu_clock_domain = ck[`SCG_CK_CPU];
    assign flash_clock_domain = ck[`SCG_CK_FLASH];
    assign io_clock_domain = ck[`SCG_CK_IO];
    assign converter_clock_domain = ck[`SCG_CK_CONV];
    assign async_clock_domain = ck[`SCG_CK_ASY];
    assign main_osc_en = ck[`SCG_CK_MAIN];
    assign timer_osc_en = ck[`SCG_CK_TOSC];

    property p_enter_needs_se;
        $rose(in_sleep) |-> $past(sleep_enable_bit) && $past(sleep_instr);
    endproperty
    a_enter_needs_se: assert property (p_enter_needs_se)
        else $error("sleep entered without sleep enable");
    property p_stby_wake_six;
        (st == scg_pkg::SCG_SLEEP && wake_hit && mode_q[2])
            |=> !cpu_clock_domain [*6] ##1 cpu_clock_domain;
    endproperty
    a_stby_wake_six: assert property (p_stby_wake_six)
        else $error("standby wake not six cycles");
    property p_idle_wake_four;
        (st == scg_pkg::SCG_SLEEP && wake_hit && mode_q[2:1] == 2'h0)
            |=> (!cpu_clock_domain && io_clock_domain) [*4]
            ##1 cpu_clock_domain;
    endproperty
    a_idle_wake_four: assert property (p_idle_wake_four)
        else $error("idle wake halt not four cycles");
    property p_idle_gating;
        (st == scg_pkg::SCG_SLEEP && mode_q == `SCG_MODE_IDLE)
            |-> io_clock_domain && !flash_clock_domain && main_osc_en;
    endproperty
    a_idle_gating: assert property (p_idle_gating)
        else $error("idle gating wrong");
    property p_async_follows_sel;
        ($past(st) == scg_pkg::SCG_SLEEP && st == scg_pkg::SCG_SLEEP &&
            mode_q[1:0] == 2'h3)
            |-> async_clock_domain == $past(async_timer_clock_select);
    endproperty
    a_async_follows_sel: assert property (p_async_follows_sel)
        else $error("async domain ignores select bit");
    // State and outputs are registered together, so no lag here
    property p_comp_off_deep;
        (st == scg_pkg::SCG_SLEEP && mode_q[2:1] != 2'h0)
            |-> !comparator_power && !io_clock_domain && !input_buf_en;
    endproperty
    a_comp_off_deep: assert property (p_comp_off_deep)
        else $error("comparator or buffers on in deep sleep");
    property p_debug_keeps_main;
        ($past(st) == scg_pkg::SCG_SLEEP && $past(debug_keep) &&
            $past(mode_q) == `SCG_MODE_PDOWN) |-> main_osc_en;
    endproperty
    a_debug_keeps_main: assert property (p_debug_keeps_main)
        else $error("main clock stopped with debug enabled");
    property p_tdo_drive;
        !scan_data_oe_n |-> $past(scan_en) && $past(tap_shifting);
    endproperty
    a_tdo_drive: assert property (p_tdo_drive)
        else $error("scan output driven while not shifting");
    property p_ext_conv;
        $rose(converter_enable) |=> extended_conv;
    endproperty
    a_ext_conv: assert property (p_ext_conv)
        else $error("extended conversion not flagged");
    property p_vref_comp;
        (comparator_enable && comparator_uses_ref) |=> vref_power;
    endproperty
    a_vref_comp: assert property (p_vref_comp)
        else $error("reference off while comparator uses it");

endmodule // scg_sleep_ctrl

// file: dv/scg_cpu_model.sv
`timescale 1ns/1ps

module scg_cpu_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic req_sleep,
    input wire logic [7:0] wake_req,
    input wire logic scan_data_out,
    input wire logic scan_data_oe_n,
    output logic sleep_instr,
    output logic [7:0] wake,
    output wire logic tdo_pin
);
    // Sleep instruction on every other cycle while requested; sources hold until told to drop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sleep_instr <= 1'h0;
            wake <= 8'h00;
        end else begin
            sleep_instr <= req_sleep && !sleep_instr;
            wake <= wake_req;
        end
    end
    // Board pull-up holds the pin high while it floats
    assign tdo_pin = scan_data_oe_n ? 1'h1 : scan_data_out;
endmodule // scg_cpu_model

// file: dv/scg_sleep_ctrl_tb_top.sv
`timescale 1ns/1ps

module scg_sleep_ctrl_tb_top;
    localparam logic [15:0] SU = 16'h0003;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic req, tdo;
    logic [7:0] wreq, wk;
    logic sleep_instr, sleep_enable_bit, xtal_clock_source;
    logic [2:0] sleep_mode_select, ext_irq_buf_en;
    logic async_timer_clock_select, ext_irq_zero, ext_irq_one, ext_irq_two;
    logic ext_irq_zero_level, ext_irq_one_level, two_wire_serial_match;
    logic timer2_irq, self_program_store_ready, converter_done;
    logic other_io_irq, converter_enable, conversion_start;
    logic comparator_enable, comparator_uses_ref, brownout_enable_fuse;
    logic watchdog_enable, debug_enable_fuse, scan_port_enable_fuse;
    logic scan_port_disable_bit, tap_shifting, tap_data_out;
    logic cpu_clock_domain, flash_clock_domain, io_clock_domain;
    logic converter_clock_domain, async_clock_domain, main_osc_en;
    logic timer_osc_en, in_sleep, converter_power, comparator_power;
    logic vref_power, brownout_power, watchdog_run, input_buf_en;
    logic extended_conv, scan_data_out, scan_data_oe_n;
    scg_pkg::scg_clk_t clks;
    int n_errors = 0;
    int n_checks = 0;

    assign clks = {cpu_clock_domain, flash_clock_domain, io_clock_domain,
        converter_clock_domain, async_clock_domain, main_osc_en,
        timer_osc_en};
    assign {ext_irq_two, ext_irq_one, ext_irq_zero, other_io_irq,
        converter_done, self_program_store_ready, timer2_irq,
        two_wire_serial_match} = wk;

    scg_sleep_ctrl #(.STARTUP_CYC(SU)) scg_sleep_ctrl_i (.*);

    scg_cpu_model scg_cpu_model_i (
        .clk(clk),
        .rst(rst),
        .req_sleep(req),
        .wake_req(wreq),
        .scan_data_out(scan_data_out),
        .scan_data_oe_n(scan_data_oe_n),
        .sleep_instr(sleep_instr),
        .wake(wk),
        .tdo_pin(tdo)
    );

    always #5 clk = ~clk;

    task give_verdict();
        if (n_errors == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task chk_val(input logic [15:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task chk_clk(input scg_pkg::scg_clk_t got, exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Stand-by modes without a crystal fall back to the deep modes
    function automatic logic [2:0] eff(input logic [2:0] m, input logic x);
        return (m[2] && !x) ? {1'h0, m[1:0]} : m;
    endfunction

    function automatic scg_pkg::scg_clk_t exp_clk(input logic [2:0] m);
        logic a, d;
        a = async_timer_clock_select;
        d = debug_enable_fuse & scan_port_enable_fuse & !scan_port_disable_bit;
        case (m)
            3'h0: return {4'h3, 1'h1, 1'h1, a};
            3'h1: return {4'h1, 1'h1, 1'h1, a};
            3'h2: return {4'h0, 1'h0, d, 1'h0};
            3'h3: return {4'h0, a, d, a};
            3'h6: return {4'h0, 1'h0, 1'h1, 1'h0};
            default: return {4'h0, a, 1'h1, a};
        endcase
    endfunction

    function automatic logic exp_acc(input logic [2:0] m, input int s);
        if (s == 0 || s == 7 || m == 3'h0) return 1'h1;
        if (s == 5) return ext_irq_zero_level;
        if (s == 6) return ext_irq_one_level;
        if (s == 1) return m == 3'h1 || (m[1:0] == 2'h3 &&
            async_timer_clock_select);
        return m == 3'h1 && s != 4;
    endfunction

    task automatic wait_wake(output logic w);
        int i;
        w = 1'h0;
        for (i = 0; i < 12 && !w; i++) begin
            @(posedge clk);
            #1;
            w = in_sleep === 1'h0;
        end
    endtask

    task automatic run_one(input logic [2:0] m, input logic x, a,
            input int s);
        logic [31:0] r;
        logic [2:0] e;
        logic w, ib;
        int n;
        r = $urandom;
        @(posedge clk);
        sleep_mode_select <= m;
        xtal_clock_source <= x;
        async_timer_clock_select <= a;
        sleep_enable_bit <= r[11:10] != 2'h0;
        {ext_irq_zero_level, ext_irq_one_level, converter_enable,
            comparator_enable, comparator_uses_ref, brownout_enable_fuse,
            watchdog_enable, debug_enable_fuse, scan_port_enable_fuse,
            scan_port_disable_bit} <= r[9:0];
        repeat (6) @(posedge clk);
        req <= 1'h1;
        @(posedge clk) req <= 1'h0;
        repeat (4) @(posedge clk);
        #1;
        e = eff(m, x);
        ib = e <= 3'h1;
        if (!sleep_enable_bit || m[2:1] == 2'h2) begin
            chk_val(in_sleep, 1'h0);
            chk_clk(clks, {6'h3F, a});
            return;
        end
        chk_val(in_sleep, 1'h1);
        chk_clk(clks, exp_clk(e));
        chk_val({converter_power, brownout_power, watchdog_run},
            {converter_enable, brownout_enable_fuse,
            watchdog_enable});
        chk_val(comparator_power, comparator_enable & ib);
        chk_val(vref_power, brownout_enable_fuse | converter_enable |
            (comparator_enable & (comparator_uses_ref | ib)));
        chk_val({input_buf_en, ext_irq_buf_en}, {ib, 1'h1,
            ext_irq_one_level | ib, ext_irq_zero_level | ib});
        @(posedge clk) wreq <= 8'h01 << s;
        wait_wake(w);
        chk_val(w, exp_acc(e, s));
        if (!w) begin
            @(posedge clk) wreq <= 8'h01;
            wait_wake(w);
            chk_val(w, 1'h1);
        end
        chk_clk(clks, {6'h0F, a});
        for (n = 0; n < 40 && cpu_clock_domain !== 1'h1; n++) begin
            @(posedge clk);
            #1;
        end
        chk_val(16'(n), e <= 3'h1 ? 16'h4 :
            e[2] ? 16'h6 : SU + 16'h4);
        chk_clk(clks, {6'h3F, a});
        @(posedge clk) wreq <= 8'h00;
    endtask

    initial begin
        #200000;
        n_errors++;
        give_verdict();
    end

    initial begin
        logic [31:0] r;
        logic en;
        {req, wreq, sleep_enable_bit, sleep_mode_select, xtal_clock_source,
            async_timer_clock_select, ext_irq_zero_level, ext_irq_one_level,
            converter_enable, conversion_start, comparator_enable,
            comparator_uses_ref, brownout_enable_fuse, watchdog_enable,
            debug_enable_fuse, scan_port_enable_fuse, scan_port_disable_bit,
            tap_shifting, tap_data_out} = '0;
        r = $urandom(32'hD1FD74E3);
        repeat (15) @(posedge clk);
        #1;
        chk_clk(clks, 7'h7E);
        chk_val({in_sleep, vref_power, input_buf_en, ext_irq_buf_en,
            scan_data_oe_n, extended_conv}, 16'h3E);
        @(posedge clk) rst <= 1'h0;
        run_one(3'h7, 1'h1, 1'h1, 1);
        run_one(3'h6, 1'h0, 1'h1, 7);
        run_one(3'h4, 1'h1, 1'h0, 0);
        run_one(3'h2, 1'h1, 1'h0, 4);
        run_one(3'h1, 1'h1, 1'h0, 4);
        run_one(3'h3, 1'h1, 1'h0, 1);
        repeat (40) begin
            r = $urandom;
            run_one(r[2:0], r[3], r[4], int'(r[7:5]));
        end
        repeat (24) begin
            r = $urandom;
            @(posedge clk);
            {scan_port_enable_fuse, scan_port_disable_bit, tap_shifting,
                tap_data_out} <= r[3:0];
            en = r[3] & !r[2] & r[1];
            @(posedge clk);
            #1;
            chk_val({scan_data_oe_n, tdo}, {!en, en ? r[0] : 1'h1});
        end
        @(posedge clk) converter_enable <= 1'h0;
        repeat (3) @(posedge clk);
        conversion_start <= 1'h1;
        @(posedge clk) conversion_start <= 1'h0;
        repeat (2) @(posedge clk);
        #1 chk_val(extended_conv, 1'h0);
        @(posedge clk) converter_enable <= 1'h1;
        repeat (3) @(posedge clk);
        #1 chk_val(extended_conv, 1'h1);
        @(posedge clk) conversion_start <= 1'h1;
        @(posedge clk) conversion_start <= 1'h0;
        repeat (2) @(posedge clk);
        #1 chk_val(extended_conv, 1'h0);
        give_verdict();
    end
endmodule // scg_sleep_ctrl_tb_top
